// ### include/sccl_pkg.sv
// constants of the smart card character link block
package sccl_pkg;
	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FD   = 8'h04;
	localparam logic [7:0] OFF_TX   = 8'h08;
	localparam logic [7:0] OFF_RX   = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_SEC  = 8'h14;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_INV   = 0;
	localparam int CTRL_MSB   = 1;
	localparam int CTRL_T0    = 2;
	localparam int CTRL_SPEC  = 3;
	localparam int FD_DLOG_LO = 16;
	localparam int ST_RXV     = 0;
	localparam int ST_TXP     = 1;
	localparam int ST_PERR    = 2;
	localparam int ST_NACK    = 3;
	localparam int ST_COLD    = 4;
	localparam int ST_SPEC    = 5;
	localparam int ST_INRST   = 6;
	localparam int ST_CSTOP   = 7;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [3:0]  CTRL_RST = 4'h4;
	localparam logic [11:0] F_DFLT   = 12'h174;
	localparam logic [2:0]  DLOG_DFLT = 3'h0;
	// ************************************************************
	// bit positions inside a frame, in etu
	// ************************************************************
	localparam logic [3:0] BIT_START = 4'h0;
	localparam logic [3:0] BIT_PAR   = 4'h9;
	localparam logic [3:0] BIT_ERR   = 4'ha;
	localparam logic [3:0] BIT_GUARD = 4'hb;
	localparam logic [3:0] BIT_RETRY = 4'hc;
	typedef enum logic [1:0] {S_IDLE, S_RX, S_TX} sccl_state_e;
endpackage

// ### rtl/sccl_top.sv
// card-side character link on the single i/o line, with apb registers
// Operation
// - first reset after power-up is cold
// - cold reset enters negotiable mode
// - any reset clears security status
// - warm reset may keep previous protocol and F/D
// - same answer framing after every warm reset
// - clock stop support shown in status
// - card always signals errors in T=0
// - exchange only after reset answer completes
// - line idles high, convention sets polarity
// - frame is start, 8 data, parity
// - parity makes ones count even
// - confirm start, sample at n plus half
// - guard time with line high between characters
// - bit order follows convention, msb byte first; the code takes the bit order from CTRL_MSB, separate from CTRL_INV
// - default 372/1, also 512/8 and 512/16
// - error pulse at 10.5, check at 11
// - start edges twelve etu apart
`timescale 1ns/1ps
module sccl_top #(
	parameter int  FW          = 12,
	parameter bit  CLK_STOP_OK = 1'b1
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        card_clk,
	input  wire logic        card_rst_n,
	input  wire logic        io_in,
	output logic             io_out,
	output logic             io_oe
);
	// ************************************************************
	// elaboration check
	// ************************************************************
	if (FW != 12) begin : g_fw_check
		$error("sccl_top: FW must be 12");
	end

	// ************************************************************
	// declarations
	// ************************************************************
	logic [2:0]         cclk_s, io_s, crst_s;
	logic               tick;
	sccl_pkg::sccl_state_e st_r;
	logic [3:0]         bit_r;
	logic [FW-1:0]      cyc_r;
	logic [FW-1:0]      etu;
	logic               mid, endb;
	logic [3:0]         ctrl_r;
	logic [FW-1:0]      f_r;
	logic [2:0]         dlog_r;
	logic [7:0]         txd_r, rxsh_r, rxd_r;
	logic               tx_pend_r, rxv_r, perr_r, nack_r, nack_now_r, bad_r;
	logic               seen_r, cold_r, spec_r;
	logic [31:0]        sec_r;
	logic               drive_r;
	logic               acc, wr, rd, rst_ev, in_rst, start_ev, line_bit;
	logic               tx_low, tx_bitv;
	logic [2:0]         tx_j;
	logic [31:0]        rd_mux;
	logic               unmapped;
	logic               pready_r, pslverr_r, io_oe_r;
	logic [31:0]        prdata_r;

	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;
	assign io_oe   = io_oe_r;
	assign io_out  = 1'b0;

	// ************************************************************
	// synchronisers: stage 0 feeds only stage 1
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cclk_s <= 3'h0;
			io_s   <= 3'h7;
			crst_s <= 3'h0;
		end else if (clk_en) begin
			cclk_s <= {cclk_s[1:0], card_clk};
			io_s   <= {io_s[1:0], io_in};
			crst_s <= {crst_s[1:0], card_rst_n};
		end
	end

	assign tick     = cclk_s[1] & ~cclk_s[2];
	assign in_rst   = ~crst_s[1];
	assign rst_ev   = crst_s[2] & ~crst_s[1];
	assign start_ev = io_s[2] & ~io_s[1];
	assign line_bit = io_s[1] ^ ctrl_r[sccl_pkg::CTRL_INV];

	// ************************************************************
	// etu timing
	// ************************************************************
	assign etu  = f_r >> dlog_r;
	// the first tick after a bit boundary is cycle one of the bit, so mid-bit is the (etu/2)th tick
	assign mid  = tick && (cyc_r == (etu >> 1) - 1'b1);
	assign endb = tick && (cyc_r == etu - 1'b1);

	// ************************************************************
	// apb slave: one wait state, then pready
	// ************************************************************
	assign acc = psel & penable & pready_r;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;

	always_comb begin
		rd_mux   = 32'h0;
		unmapped = 1'b0;
		if (paddr == sccl_pkg::OFF_CTRL) begin
			rd_mux[3:0] = ctrl_r;
		end else if (paddr == sccl_pkg::OFF_FD) begin
			rd_mux[FW-1:0] = f_r;
			rd_mux[sccl_pkg::FD_DLOG_LO +: 3] = dlog_r;
		end else if (paddr == sccl_pkg::OFF_TX) begin
			rd_mux[7:0] = txd_r;
		end else if (paddr == sccl_pkg::OFF_RX) begin
			rd_mux[7:0] = rxd_r;
		end else if (paddr == sccl_pkg::OFF_STAT) begin
			rd_mux[sccl_pkg::ST_RXV]   = rxv_r;
			rd_mux[sccl_pkg::ST_TXP]   = tx_pend_r;
			rd_mux[sccl_pkg::ST_PERR]  = perr_r;
			rd_mux[sccl_pkg::ST_NACK]  = nack_r;
			rd_mux[sccl_pkg::ST_COLD]  = cold_r;
			rd_mux[sccl_pkg::ST_SPEC]  = spec_r;
			rd_mux[sccl_pkg::ST_INRST] = in_rst;
			rd_mux[sccl_pkg::ST_CSTOP] = CLK_STOP_OK;
		end else if (paddr == sccl_pkg::OFF_SEC) begin
			rd_mux = sec_r;
		end else begin
			unmapped = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0;
			pslverr_r <= 1'b0;
		end else if (clk_en) begin
			pready_r  <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & unmapped;
			if (psel & penable & ~pready_r) begin
				prdata_r <= rd_mux;
			end
		end
	end

	// ************************************************************
	// reset kind, mode and transmission parameters
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			seen_r <= 1'b0;
			cold_r <= 1'b1;
			spec_r <= 1'b0;
			f_r    <= sccl_pkg::F_DFLT;
			dlog_r <= sccl_pkg::DLOG_DFLT;
		end else if (clk_en) begin
			if (rst_ev) begin
				seen_r <= 1'b1;
				cold_r <= ~seen_r;
				if (~seen_r | ~ctrl_r[sccl_pkg::CTRL_SPEC]) begin
					// negotiable: back to default factors
					spec_r <= 1'b0;
					f_r    <= sccl_pkg::F_DFLT;
					dlog_r <= sccl_pkg::DLOG_DFLT;
				end else begin
					spec_r <= 1'b1;  // factors kept from last session
				end
			end else if (wr && paddr == sccl_pkg::OFF_FD && !spec_r) begin
				// specific mode locks the factors so warm resets repeat them
				f_r    <= pwdata[FW-1:0];
				dlog_r <= pwdata[sccl_pkg::FD_DLOG_LO +: 3];
			end
		end
	end

	// convention bits survive every card reset, so warm answers match
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= sccl_pkg::CTRL_RST;
		end else if (clk_en && wr && paddr == sccl_pkg::OFF_CTRL) begin
			ctrl_r <= pwdata[3:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sec_r <= 32'h0;
		end else if (clk_en) begin
			if (rst_ev) begin
				sec_r <= 32'h0;
			end else if (wr && paddr == sccl_pkg::OFF_SEC) begin
				sec_r <= pwdata;
			end
		end
	end

	// ************************************************************
	// transmit frame bits
	// ************************************************************
	assign tx_j    = 3'(bit_r - 4'h1);
	assign tx_bitv = (bit_r == sccl_pkg::BIT_PAR) ? ^txd_r :
		(ctrl_r[sccl_pkg::CTRL_MSB] ? txd_r[3'h7 - tx_j] : txd_r[tx_j]);
	assign tx_low  = (bit_r == sccl_pkg::BIT_START) ? 1'b1 :
		(bit_r <= sccl_pkg::BIT_PAR) ? ~(tx_bitv ^ ctrl_r[sccl_pkg::CTRL_INV]) : 1'b0;

	// ************************************************************
	// character state machine
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r       <= sccl_pkg::S_IDLE;
			bit_r      <= 4'h0;
			cyc_r      <= '0;
			rxsh_r     <= 8'h0;
			bad_r      <= 1'b0;
			drive_r    <= 1'b0;
			nack_now_r <= 1'b0;
		end else if (clk_en) begin
			if (in_rst) begin
				// transmission only starts once the terminal releases reset
				st_r    <= sccl_pkg::S_IDLE;
				drive_r <= 1'b0;
			end else begin
				if (st_r != sccl_pkg::S_IDLE && tick) begin
					if (endb) begin
						cyc_r <= '0;
						bit_r <= bit_r + 4'h1;
					end else begin
						cyc_r <= cyc_r + 1'b1;
					end
				end
				case (st_r)
					sccl_pkg::S_IDLE: begin
						drive_r <= 1'b0;
						if (start_ev) begin
							st_r  <= sccl_pkg::S_RX;  // fresh etu count
							bit_r <= 4'h0;
							cyc_r <= '0;
							bad_r <= 1'b0;
						end else if (tx_pend_r && io_s[1]) begin
							st_r       <= sccl_pkg::S_TX;
							bit_r      <= 4'h0;
							cyc_r      <= '0;
							nack_now_r <= 1'b0;
						end
					end
					sccl_pkg::S_RX: begin
						if (mid && bit_r == sccl_pkg::BIT_START && line_bit != ctrl_r[sccl_pkg::CTRL_INV]) begin
							st_r <= sccl_pkg::S_IDLE;  // glitch, start not confirmed
						end else if (mid && bit_r != sccl_pkg::BIT_START && bit_r < sccl_pkg::BIT_PAR) begin
							rxsh_r <= ctrl_r[sccl_pkg::CTRL_MSB] ? {rxsh_r[6:0], line_bit}
								: {line_bit, rxsh_r[7:1]};
						end else if (mid && bit_r == sccl_pkg::BIT_PAR) begin
							bad_r <= ^{rxsh_r, line_bit};
						end else if (mid && bit_r == sccl_pkg::BIT_ERR) begin
							if (bad_r && ctrl_r[sccl_pkg::CTRL_T0]) begin
								drive_r <= 1'b1;  // error pulse 10.5 to 12 etu
							end else begin
								st_r <= sccl_pkg::S_IDLE;
							end
						end else if (endb && bit_r == sccl_pkg::BIT_GUARD) begin
							drive_r <= 1'b0;
							st_r    <= sccl_pkg::S_IDLE;
						end
					end
					sccl_pkg::S_TX: begin
						drive_r <= tx_low;
						if (endb && bit_r == sccl_pkg::BIT_ERR) begin
							// line check at 11 etu
							nack_now_r <= ~io_s[1] & ctrl_r[sccl_pkg::CTRL_T0];
						end else if (endb && bit_r == sccl_pkg::BIT_GUARD && !nack_now_r) begin
							st_r <= sccl_pkg::S_IDLE;  // next start no sooner than 12 etu
						end else if (endb && bit_r == sccl_pkg::BIT_RETRY) begin
							// repeat at 13 etu, 2 etu after the
							bit_r      <= 4'h0;
							nack_now_r <= 1'b0;
						end
					end
					default: st_r <= sccl_pkg::S_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			io_oe_r <= 1'b0;
		end else if (clk_en) begin
			io_oe_r <= drive_r & ~in_rst;
		end
	end

	// ************************************************************
	// data and status flags: a hardware set beats a software clear
	// ************************************************************
	logic rx_done, tx_done, nack_set, perr_set;
	assign rx_done  = ~in_rst && st_r == sccl_pkg::S_RX && mid && bit_r == sccl_pkg::BIT_ERR
		&& !(bad_r && ctrl_r[sccl_pkg::CTRL_T0]);
	assign perr_set = ~in_rst && st_r == sccl_pkg::S_RX && mid && bit_r == sccl_pkg::BIT_ERR && bad_r;
	assign tx_done  = ~in_rst && st_r == sccl_pkg::S_TX && endb && bit_r == sccl_pkg::BIT_GUARD && !nack_now_r;
	assign nack_set = ~in_rst && st_r == sccl_pkg::S_TX && endb && bit_r == sccl_pkg::BIT_ERR
		&& ~io_s[1] && ctrl_r[sccl_pkg::CTRL_T0];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txd_r     <= 8'h0;
			tx_pend_r <= 1'b0;
		end else if (clk_en) begin
			if (rst_ev) begin
				tx_pend_r <= 1'b0;
			end else if (wr && paddr == sccl_pkg::OFF_TX && !tx_pend_r) begin
				txd_r     <= pwdata[7:0];
				tx_pend_r <= 1'b1;
			end else if (tx_done) begin
				tx_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxd_r  <= 8'h0;
			rxv_r  <= 1'b0;
			perr_r <= 1'b0;
			nack_r <= 1'b0;
		end else if (clk_en) begin
			if (rx_done) begin
				rxd_r <= rxsh_r;
				rxv_r <= 1'b1;
			end else if (rd && paddr == sccl_pkg::OFF_RX) begin
				rxv_r <= 1'b0;
			end
			if (perr_set) begin
				perr_r <= 1'b1;
			end else if (wr && paddr == sccl_pkg::OFF_STAT && pwdata[sccl_pkg::ST_PERR]) begin
				perr_r <= 1'b0;
			end
			if (nack_set) begin
				nack_r <= 1'b1;
			end else if (wr && paddr == sccl_pkg::OFF_STAT && pwdata[sccl_pkg::ST_NACK]) begin
				nack_r <= 1'b0;
			end
		end
	end

endmodule // sccl_top

// ### test/sccl_top_sva.sv
// assertion checker for the card-side character link
`timescale 1ns/1ps
module sccl_top_sva (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        card_clk,
	input wire logic        card_rst_n,
	input wire logic        io_in,
	input wire logic        io_out,
	input wire logic        io_oe
);
	// ******************************
	// bus and line properties
	// ******************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire acc = psel && penable && !pready;
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
	a_ready_after_wait: assert property (clk_en && acc |=> pready) else $error("no pready after wait");
	a_ready_in_access: assert property (pready |-> psel && penable && $past(acc)) else $error("stray pready");
	a_err_unmapped: assert property (acc && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 8'h14 |=> !pslverr)
		else $error("mapped access refused");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_quiet_in_reset: assert property (!card_rst_n [*5] |-> !io_oe) else $error("line driven in reset");
	a_drain_only: assert property (io_out == 1'b0) else $error("line driven high");
	a_start_on_idle: assert property ($rose(io_oe) |-> $past(io_in)) else $error("pull on busy line");
endmodule // sccl_top_sva

// ### test/sccl_term_model.sv
// terminal model: card clock, card reset and the terminal end of the line
`timescale 1ns/1ps
module sccl_term_model (
	output logic            card_clk,
	output logic            card_rst_n,
	output logic            term_oe,
	input  wire logic       line_lvl,
	input  wire logic [11:0] etu_cc
);
	initial card_clk = 1'b0;
	initial card_rst_n = 1'b1;
	initial term_oe = 1'b0;
	// free running; the stop mode is not exercised, so no stop wait applies
	always #160 card_clk = ~card_clk;
	task automatic wait_cc(input int n);
		repeat (n) @(posedge card_clk);
	endtask
	task automatic pulse_rst();
		card_rst_n <= 1'b0;
		wait_cc(8);
		card_rst_n <= 1'b1;
		wait_cc(8);
	endtask
	// a bad parity is only ever sent on purpose
	task automatic send_char(input logic [7:0] d, input bit inv, input bit msb, input bit bad, output bit nack);
		logic [9:0] f;
		@(posedge card_clk); // start edge on a card clock edge, so the start bit lasts a full etu
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++)
			f[i + 1] = (msb ? d[7 - i] : d[i]) ^ inv;
		f[9] = ^d ^ bad ^ inv;
		for (int i = 0; i < 10; i++) begin
			term_oe <= !f[i];
			wait_cc(etu_cc);
		end
		term_oe <= 1'b0;
		wait_cc(etu_cc + etu_cc / 4);
		nack = !line_lvl;
		wait_cc(etu_cc - etu_cc / 4);
	endtask
	task automatic recv_char(input bit inv, input bit msb, input bit sig, output logic [7:0] d, output bit ok,
		output realtime t);
		logic [9:0] f;
		@(negedge line_lvl);
		t = $realtime;
		wait_cc(etu_cc / 2);
		for (int i = 0; i < 10; i++) begin
			f[i] = line_lvl ^ inv;
			wait_cc(etu_cc);
		end
		for (int i = 0; i < 8; i++)
			d[i] = msb ? f[8 - i] : f[i + 1];
		ok = ~^f[9:1];
		term_oe <= sig;
		wait_cc(etu_cc + etu_cc / 2);
		term_oe <= 1'b0;
	endtask
endmodule // sccl_term_model

// ### test/tb_top.sv
// self-checking bench for the card-side character link
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [11:0] etu = 12'h174;
	int          num_errors = 0;
	int          check_count = 0;
	int          n;
	logic        pready, pslverr, io_out, io_oe, term_oe, card_clk, card_rst_n, err;
	bit          nk, ok;
	logic [31:0] prdata, rd;
	logic [7:0]  b;
	realtime     t0, t1;
	wire         line = !(io_oe | term_oe);
	always #20 core_clk = ~core_clk;
	sccl_top i_sccl_top (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.card_clk(card_clk), .card_rst_n(card_rst_n), .io_in(line), .io_out(io_out), .io_oe(io_oe));
	sccl_term_model i_sccl_term_model (.card_clk(card_clk), .card_rst_n(card_rst_n), .term_oe(term_oe),
		.line_lvl(line), .etu_cc(etu));
	// ******************************
	// bus tasks
	// ******************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1 && ++k < 16);
		if (k == 16)
			num_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(s, e, rd)
	endtask
	task automatic complete_run();
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ******************************
	// tests
	// ******************************
	initial begin
		#3000000;
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rchk("ctrl", sccl_pkg::OFF_CTRL, {28'h0, sccl_pkg::CTRL_RST});
		rchk("fd", sccl_pkg::OFF_FD, 32'h174);
		apb(1'b0, 8'h18, 32'h0);
		`CHK("slverr", 1'b1, err)
		`CHK("slvdata", 32'h0, rd)
		apb(1'b1, sccl_pkg::OFF_SEC, 32'ha5);
		i_sccl_term_model.pulse_rst();
		rchk("sec cold", sccl_pkg::OFF_SEC, 32'h0);
		rchk("stat cold", sccl_pkg::OFF_STAT, 32'h90);
		apb(1'b1, sccl_pkg::OFF_FD, 32'h30020);
		etu = 12'h004;
		for (int c = 0; c < 5; c++) begin // five-byte command header from the terminal
			apb(1'b1, sccl_pkg::OFF_CTRL, 32'h4 | c);
			i_sccl_term_model.send_char(8'h3b + c, c[0], c[1], 1'b0, nk);
			rchk("rx", sccl_pkg::OFF_RX, 8'h3b + c);
		end
		apb(1'b1, sccl_pkg::OFF_CTRL, 32'h4);
		i_sccl_term_model.send_char(8'h55, 1'b0, 1'b0, 1'b1, nk);
		`CHK("err pulse", 1'b1, nk)
		rchk("stat perr", sccl_pkg::OFF_STAT, 32'h94);
		apb(1'b1, sccl_pkg::OFF_TX, 32'hc5);
		i_sccl_term_model.recv_char(1'b0, 1'b0, 1'b1, b, ok, t0);
		i_sccl_term_model.recv_char(1'b0, 1'b0, 1'b0, b, ok, t1);
		`CHK("tx byte", 8'hc5, b)
		`CHK("tx par", 1'b1, ok)
		`CHK("resend gap", 1'b1, (t1 - t0) >= 15360.0)
		n = 0;
		do apb(1'b0, sccl_pkg::OFF_STAT, 32'h0); while (rd[sccl_pkg::ST_TXP] !== 1'b0 && ++n < 40);
		`CHK("nack", 1'b1, rd[sccl_pkg::ST_NACK])
		apb(1'b1, sccl_pkg::OFF_CTRL, 32'h0);
		i_sccl_term_model.send_char(8'h55, 1'b0, 1'b0, 1'b1, nk);
		`CHK("no pulse", 1'b0, nk)
		rchk("rx bad", sccl_pkg::OFF_RX, 32'h55);
		apb(1'b1, sccl_pkg::OFF_STAT, 32'hc);
		apb(1'b1, sccl_pkg::OFF_CTRL, 32'hc);
		apb(1'b1, sccl_pkg::OFF_SEC, 32'h3c);
		i_sccl_term_model.pulse_rst();
		rchk("sec warm", sccl_pkg::OFF_SEC, 32'h0);
		rchk("stat warm", sccl_pkg::OFF_STAT, 32'ha0);
		apb(1'b1, sccl_pkg::OFF_FD, 32'h30200);
		rchk("fd kept", sccl_pkg::OFF_FD, 32'h30020);
		i_sccl_term_model.send_char(8'ha7, 1'b0, 1'b0, 1'b0, nk);
		rchk("rx warm", sccl_pkg::OFF_RX, 32'ha7);
		apb(1'b1, sccl_pkg::OFF_CTRL, 32'h4);
		i_sccl_term_model.pulse_rst();
		rchk("stat neg", sccl_pkg::OFF_STAT, 32'h80);
		rchk("fd dflt", sccl_pkg::OFF_FD, 32'h174);
		apb(1'b1, sccl_pkg::OFF_FD, 32'h30200);
		rchk("fd 512/8", sccl_pkg::OFF_FD, 32'h30200);
		apb(1'b1, sccl_pkg::OFF_FD, 32'h40200);
		rchk("fd 512/16", sccl_pkg::OFF_FD, 32'h40200);
		complete_run();
	end
endmodule // tb_top
bind sccl_top sccl_top_sva i_sccl_top_sva (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .card_clk(card_clk), .card_rst_n(card_rst_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
